// [core/ssrr_regs.vh]
// Constants for the serial status readout register bank.
// Assumes inclusion by core/ssrr_readout.v only; definitions only.
`ifndef SSRR_REGS_VH
`define SSRR_REGS_VH

// Word layout
`define SSRR_WORD_BITS 16
`define SSRR_ADDR_MSB 15
`define SSRR_ADDR_LSB 12
`define SSRR_DATA_BITS 12
`define SSRR_BIT_CNT_FULL 5'h10

// Register addresses
`define SSRR_ADDR_UNUSED0 4'h0
`define SSRR_ADDR_QUICK_STATUS 4'h1
`define SSRR_ADDR_CHANNEL1_STATUS 4'h2
`define SSRR_ADDR_CHANNEL2_STATUS 4'h3
`define SSRR_ADDR_CHANNEL3_STATUS 4'h4
`define SSRR_ADDR_CHANNEL4_STATUS 4'h5
`define SSRR_ADDR_UNUSED6 4'h6
`define SSRR_ADDR_DEVICE_STATUS 4'h7
`define SSRR_ADDR_IO_STATUS 4'h8
`define SSRR_ADDR_IDENTIFICATION 4'h9
`define SSRR_ADDR_TEST_MODE_REG 4'hF

// Header bits: fail mode on addresses 1..8, summaries on 1..7, neither on 6
`define SSRR_BIT_FAIL_MODE 11
`define SSRR_BIT_DEVICE_SUMMARY 10
`define SSRR_BIT_OVERLOAD_SUMMARY 9
`define SSRR_BIT_OPEN_LOAD_SUMMARY 8

// Quick status fields
`define SSRR_BIT_CHARGE_PUMP 7
`define SSRR_BIT_REGS_CLEARED 6
`define SSRR_BIT_PWM_CLOCK_FAIL 5

// Channel status fields
`define SSRR_BIT_OT_SHUTDOWN 6
`define SSRR_BIT_OT_WARNING 5
`define SSRR_OC_CODE_MSB 4
`define SSRR_OC_CODE_LSB 2
`define SSRR_BIT_OL_ON 1
`define SSRR_BIT_OL_OFF 0

// Overcurrent codes
`define SSRR_OC_NONE 3'h0
`define SSRR_OC_HIGH_STAGE1 3'h1
`define SSRR_OC_HIGH_STAGE2 3'h2
`define SSRR_OC_HIGH_STAGE3 3'h3
`define SSRR_OC_LOW_THRESHOLD 3'h4
`define SSRR_OC_HIGH_OFF_DELAY 3'h5
`define SSRR_OC_SEVERE_SHORT 3'h6
`define SSRR_OC_UNUSED 3'h7

// Device status fields
`define SSRR_BIT_TEST_MODE 4
`define SSRR_BIT_OVERVOLTAGE 3
`define SSRR_BIT_UNDERVOLTAGE 2
`define SSRR_BIT_SERIAL_FAIL 1
`define SSRR_BIT_LIMP_HOME 0

// I/O status fields
`define SSRR_BIT_TOGGLE 9

// Reset values
`define SSRR_RCF_RESET 1'h1
`define SSRR_RESP_ADDR_RESET 4'h0
`define SSRR_PIN_SYNC_RESET 8'h01

`endif

// [core/ssrr_readout.v]
// Serial status readout register bank of a four-channel high-side switch.
// Assumes the serial pins arrive asynchronously to clk, the fault detector
// outputs come from logic on clk, and the host drives SO's wire from so_oe.
`include "ssrr_regs.vh"
`default_nettype none

// Sticky fault flags of one channel, cleared by a good read of its status.
// A fresh event beats a clear in the same cycle, so a fault in the clearing cycle is kept.
module ssrr_chan_latch (
  input wire clk,
  input wire reset_n,
  input wire clr,
  input wire ots_evt,
  input wire otw_evt,
  input wire [2:0] oc_evt,
  input wire olon_evt,
  input wire oloff_evt,
  output reg ots_q,
  output reg otw_q,
  output reg [2:0] oc_q,
  output reg olon_q,
  output reg oloff_q
);

  always @(posedge clk) begin
    if (!reset_n) begin
      ots_q <= 1'b0;
      otw_q <= 1'b0;
      oc_q <= `SSRR_OC_NONE;
      olon_q <= 1'b0;
      oloff_q <= 1'b0;
    end else begin
      ots_q <= (ots_q & ~clr) | ots_evt;
      otw_q <= (otw_q & ~clr) | otw_evt;
      olon_q <= (olon_q & ~clr) | olon_evt;
      oloff_q <= (oloff_q & ~clr) | oloff_evt;
      if (oc_evt != `SSRR_OC_NONE && oc_evt != `SSRR_OC_UNUSED) begin
        // The latest code other than none or unused replaces an older one
        oc_q <= oc_evt;
      end else if (clr) begin
        oc_q <= `SSRR_OC_NONE;
      end
    end
  end

endmodule

module ssrr_readout #(
  parameter CHANNELS = 4,
  // Arbitrary neutral identity value
  parameter [7:0] IDENTITY_FIELD = 8'h06
) (
  input wire clk,
  input wire reset_n,
  input wire spi_cs_n_pin,
  input wire spi_sclk_pin,
  input wire spi_si_pin,
  output reg spi_so_out,
  output reg spi_so_oe,
  input wire fail_mode_flag,
  input wire charge_pump_fault,
  input wire pwm_clock_fail,
  input wire test_mode_active_flag,
  input wire overvoltage_flag,
  input wire undervoltage_flag,
  input wire limp_home_pin_level,
  input wire [CHANNELS-1:0] overtemp_shutdown,
  input wire [CHANNELS-1:0] overtemp_warning,
  input wire [3*CHANNELS-1:0] overcurrent_code,
  input wire [CHANNELS-1:0] open_load_on_state,
  input wire [CHANNELS-1:0] open_load_off_state,
  input wire [CHANNELS-1:0] channel_input_level,
  input wire [CHANNELS-1:0] channel_input_active,
  input wire [CHANNELS-1:0] output_comparator_level
);

  // Pin synchronisers: {comparators, limp, si, sclk, cs_n}
  reg [7:0] pin_s1_q;
  reg [7:0] pin_s2_q;
  reg sclk_prev_q;
  reg cs_n_prev_q;

  // Serial frame state
  reg [15:0] tx_q;
  reg [15:0] rx_q;
  reg [4:0] bit_cnt_q;
  reg [3:0] resp_addr_q;
  reg [3:0] sent_addr_q;

  // Latched fault flags
  wire [CHANNELS-1:0] ots_q;
  wire [CHANNELS-1:0] otw_q;
  wire [3*CHANNELS-1:0] oc_q;
  wire [CHANNELS-1:0] olon_q;
  wire [CHANNELS-1:0] oloff_q;
  reg cpf_q;
  reg pwm_clock_fail_q;
  reg rcf_q;
  reg tmf_q;
  reg ovf_q;
  reg uvf_q;
  reg serial_fail_flag_q;

  wire [7:0] pin_raw;
  wire cs_n_s;
  wire sclk_s;
  wire si_s;
  wire limp_s;
  wire [3:0] outcmp_s;
  wire cs_fall;
  wire cs_rise;
  wire sclk_rise;
  wire sclk_fall;
  wire frame_ok;
  wire frame_bad;
  wire [CHANNELS-1:0] oc_active;
  wire [CHANNELS-1:0] chan_clr;
  wire [CHANNELS-1:0] quick_flag;
  wire overload_sum;
  wire open_load_sum;
  wire device_sum;
  wire quick_clr;
  wire device_clr;
  wire fm_slot;
  wire sum_slot;
  reg [11:0] data_mux;
  reg [11:0] chan_data;
  integer k;

  assign pin_raw = {output_comparator_level[3:0], limp_home_pin_level, spi_si_pin, spi_sclk_pin, spi_cs_n_pin};
  assign cs_n_s = pin_s2_q[0];
  assign sclk_s = pin_s2_q[1];
  assign si_s = pin_s2_q[2];
  assign limp_s = pin_s2_q[3];
  assign outcmp_s = pin_s2_q[7:4];

  always @(posedge clk) begin
    if (!reset_n) begin
      pin_s1_q <= `SSRR_PIN_SYNC_RESET;
      pin_s2_q <= `SSRR_PIN_SYNC_RESET;
      sclk_prev_q <= 1'b0;
      cs_n_prev_q <= 1'b1;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      sclk_prev_q <= sclk_s;
      cs_n_prev_q <= cs_n_s;
    end
  end

  assign cs_fall = cs_n_prev_q & ~cs_n_s;
  assign cs_rise = ~cs_n_prev_q & cs_n_s;
  assign sclk_rise = ~sclk_prev_q & sclk_s & ~cs_n_s;
  assign sclk_fall = sclk_prev_q & ~sclk_s & ~cs_n_s;
  // A frame counts only with exactly one full word; anything else is a serial fault
  assign frame_ok = cs_rise & (bit_cnt_q == `SSRR_BIT_CNT_FULL);
  assign frame_bad = cs_rise & (bit_cnt_q != `SSRR_BIT_CNT_FULL);

  // Reading a register in a good frame clears its latched flags; a fresh event wins
  assign quick_clr = frame_ok & (sent_addr_q == `SSRR_ADDR_QUICK_STATUS);
  assign device_clr = frame_ok & (sent_addr_q == `SSRR_ADDR_DEVICE_STATUS);

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : gen_chan
      assign chan_clr[g] = frame_ok & (sent_addr_q == `SSRR_ADDR_CHANNEL1_STATUS + g);
      assign oc_active[g] = oc_q[3*g+2:3*g] != `SSRR_OC_NONE;
      assign quick_flag[g] = oc_active[g] | otw_q[g] | ots_q[g] | olon_q[g] | oloff_q[g];

      ssrr_chan_latch u_latch (
        .clk(clk),
        .reset_n(reset_n),
        .clr(chan_clr[g]),
        .ots_evt(overtemp_shutdown[g]),
        .otw_evt(overtemp_warning[g]),
        .oc_evt(overcurrent_code[3*g+2:3*g]),
        .olon_evt(open_load_on_state[g]),
        .oloff_evt(open_load_off_state[g]),
        .ots_q(ots_q[g]),
        .otw_q(otw_q[g]),
        .oc_q(oc_q[3*g+2:3*g]),
        .olon_q(olon_q[g]),
        .oloff_q(oloff_q[g])
      );
    end
  endgenerate

  always @(posedge clk) begin
    if (!reset_n) begin
      cpf_q <= 1'b0;
      pwm_clock_fail_q <= 1'b0;
      rcf_q <= `SSRR_RCF_RESET;
      tmf_q <= 1'b0;
      ovf_q <= 1'b0;
      uvf_q <= 1'b0;
      serial_fail_flag_q <= 1'b0;
    end else begin
      cpf_q <= (cpf_q & ~quick_clr) | charge_pump_fault;
      pwm_clock_fail_q <= (pwm_clock_fail_q & ~quick_clr) | pwm_clock_fail;
      // Only a reset sets this flag, so the first good quick status read drops it
      rcf_q <= rcf_q & ~quick_clr;
      tmf_q <= (tmf_q & ~device_clr) | test_mode_active_flag;
      ovf_q <= (ovf_q & ~device_clr) | overvoltage_flag;
      uvf_q <= (uvf_q & ~device_clr) | undervoltage_flag;
      serial_fail_flag_q <= (serial_fail_flag_q & ~device_clr) | frame_bad;
    end
  end

  assign overload_sum = (|oc_active) | (|ots_q);
  assign open_load_sum = (|olon_q) | (|oloff_q);
  assign device_sum = rcf_q | uvf_q | ovf_q | cpf_q | pwm_clock_fail_q | tmf_q;

  // Address 6 is a hole in the map, so it carries no header bits either
  assign fm_slot = (resp_addr_q >= `SSRR_ADDR_QUICK_STATUS) && (resp_addr_q <= `SSRR_ADDR_IO_STATUS) &&
                   (resp_addr_q != `SSRR_ADDR_UNUSED6);
  assign sum_slot = (resp_addr_q >= `SSRR_ADDR_QUICK_STATUS) && (resp_addr_q <= `SSRR_ADDR_DEVICE_STATUS) &&
                    (resp_addr_q != `SSRR_ADDR_UNUSED6);

  // Channel status of the addressed channel
  always @* begin
    chan_data = 12'h000;
    for (k = 0; k < CHANNELS; k = k + 1) begin
      if (resp_addr_q == `SSRR_ADDR_CHANNEL1_STATUS + k) begin
        chan_data[`SSRR_BIT_OT_SHUTDOWN] = ots_q[k];
        chan_data[`SSRR_BIT_OT_WARNING] = otw_q[k];
        chan_data[`SSRR_OC_CODE_MSB:`SSRR_OC_CODE_LSB] = oc_q[3*k+2 -: 3];
        chan_data[`SSRR_BIT_OL_ON] = olon_q[k];
        chan_data[`SSRR_BIT_OL_OFF] = oloff_q[k];
      end
    end
  end

  // Data of the register returned in the coming frame
  always @* begin
    data_mux = 12'h000;
    case (resp_addr_q)
      `SSRR_ADDR_QUICK_STATUS: begin
        data_mux[`SSRR_BIT_CHARGE_PUMP] = cpf_q;
        data_mux[`SSRR_BIT_REGS_CLEARED] = rcf_q;
        data_mux[`SSRR_BIT_PWM_CLOCK_FAIL] = pwm_clock_fail_q;
        data_mux[3:0] = quick_flag[3:0];
      end
      `SSRR_ADDR_CHANNEL1_STATUS,
      `SSRR_ADDR_CHANNEL2_STATUS,
      `SSRR_ADDR_CHANNEL3_STATUS,
      `SSRR_ADDR_CHANNEL4_STATUS: begin
        data_mux = chan_data;
      end
      `SSRR_ADDR_DEVICE_STATUS: begin
        data_mux[`SSRR_BIT_TEST_MODE] = tmf_q;
        data_mux[`SSRR_BIT_OVERVOLTAGE] = ovf_q;
        data_mux[`SSRR_BIT_UNDERVOLTAGE] = uvf_q;
        data_mux[`SSRR_BIT_SERIAL_FAIL] = serial_fail_flag_q;
        data_mux[`SSRR_BIT_LIMP_HOME] = limp_s;
      end
      `SSRR_ADDR_IO_STATUS: begin
        data_mux[`SSRR_BIT_TOGGLE] = |channel_input_active;
        data_mux[8:5] = channel_input_level[3:0];
        data_mux[3:0] = outcmp_s;
      end
      `SSRR_ADDR_IDENTIFICATION: begin
        data_mux[7:0] = IDENTITY_FIELD;
      end
      default: begin
        data_mux = 12'h000;
      end
    endcase
    // Fail mode heads 1..8, the summaries head 1..7, neither heads 6
    if (fm_slot) begin
      data_mux[`SSRR_BIT_FAIL_MODE] = fail_mode_flag;
    end
    if (sum_slot) begin
      data_mux[`SSRR_BIT_DEVICE_SUMMARY] = device_sum;
      data_mux[`SSRR_BIT_OVERLOAD_SUMMARY] = overload_sum;
      data_mux[`SSRR_BIT_OPEN_LOAD_SUMMARY] = open_load_sum;
    end
  end

  // Shift engine: SO changes after SCLK rises, SI is taken as SCLK falls
  always @(posedge clk) begin
    if (!reset_n) begin
      tx_q <= 16'h0000;
      rx_q <= 16'h0000;
      bit_cnt_q <= 5'h00;
      resp_addr_q <= `SSRR_RESP_ADDR_RESET;
      sent_addr_q <= `SSRR_RESP_ADDR_RESET;
      spi_so_out <= 1'b0;
      spi_so_oe <= 1'b0;
    end else if (cs_fall) begin
      // Snapshot taken at frame start so the word cannot tear mid-shift
      tx_q <= {resp_addr_q, data_mux};
      spi_so_out <= resp_addr_q[3];
      spi_so_oe <= 1'b1;
      bit_cnt_q <= 5'h00;
      sent_addr_q <= resp_addr_q;
    end else if (cs_rise) begin
      spi_so_oe <= 1'b0;
      spi_so_out <= 1'b0;
      if (frame_ok) begin
        resp_addr_q <= rx_q[`SSRR_ADDR_MSB:`SSRR_ADDR_LSB];
      end
    end else begin
      if (sclk_rise && bit_cnt_q != 5'h00) begin
        tx_q <= {tx_q[14:0], 1'b0};
        spi_so_out <= tx_q[14];
      end
      if (sclk_fall) begin
        rx_q <= {rx_q[14:0], si_s};
        // Saturates so an overlong frame is still seen as wrong
        if (bit_cnt_q != 5'h1F) begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
        end
      end
    end
  end

endmodule

`default_nettype wire

// [tb/ssrr_checker.sv]
// Port-level timing checks for the serial readout bank.
// Assumes pins change away from the rising edge of clk.
`default_nettype none
module ssrr_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic spi_cs_n_pin,
  input wire logic spi_sclk_pin,
  input wire logic spi_so_out,
  input wire logic spi_so_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_oe_on; $fell(spi_cs_n_pin) |-> ##[2:4] spi_so_oe; endproperty
  property p_oe_off; $rose(spi_cs_n_pin) |-> ##[2:4] !spi_so_oe; endproperty
  property p_oe_hold; !spi_cs_n_pin [*5] |-> spi_so_oe; endproperty
  property p_quiet; spi_cs_n_pin [*5] |-> !spi_so_oe && !spi_so_out; endproperty
  property p_so_zero; !spi_so_oe |-> !spi_so_out; endproperty
  property p_reset; disable iff (1'b0) !reset_n |=> !spi_so_oe && !spi_so_out; endproperty
  // SO may only move a few cycles after a serial clock rise
  property p_shift; spi_so_oe && $past(spi_so_oe) && $changed(spi_so_out) |-> $past(spi_sclk_pin, 2); endproperty
  property p_oe_cause; $rose(spi_so_oe) |-> !$past(spi_cs_n_pin, 2); endproperty
  a_oe_on: assert property (p_oe_on) else $error("SO enable late");
  a_oe_off: assert property (p_oe_off) else $error("SO release late");
  a_oe_hold: assert property (p_oe_hold) else $error("SO enable dropped in frame");
  a_quiet: assert property (p_quiet) else $error("SO active outside frame");
  a_so_zero: assert property (p_so_zero) else $error("SO data while released");
  a_reset: assert property (p_reset) else $error("SO active after reset");
  a_shift: assert property (p_shift) else $error("SO moved without clock rise");
  a_oe_cause: assert property (p_oe_cause) else $error("SO enable without select");
  c_start: cover property ($fell(spi_cs_n_pin));
  c_shift: cover property (spi_so_oe && $changed(spi_so_out));
  c_end: cover property ($fell(spi_so_oe));
endmodule
bind ssrr_readout ssrr_checker u_chk (.clk(clk), .reset_n(reset_n), .spi_cs_n_pin(spi_cs_n_pin),
  .spi_sclk_pin(spi_sclk_pin), .spi_so_out(spi_so_out), .spi_so_oe(spi_so_oe));
`default_nettype wire

// [tb/ssrr_host.sv]
// Serial bus master model standing in for the microcontroller.
// Assumes clk is the device clock; pins move on its falling edge.
`default_nettype none
module ssrr_host (
  input wire logic clk,
  output logic cs_n,
  output logic sclk,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_q = 1'b0;
  // A released SO line must not look like the last bit
  wire so_w = so_oe ? so : ~last_q;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  // MSB first, SI set at rise, SO taken at fall; gap is clocks per half period
  task automatic frame(input logic [15:0] tx, input int nb, input int gap, output logic [15:0] rx);
    rx = 16'h0000;
    @(negedge clk) cs_n = 1'b0;
    repeat (gap) @(negedge clk);
    for (int i = 0; i < nb; i++) begin
      sclk = 1'b1;
      si = tx[15 - i];
      repeat (gap) @(negedge clk);
      sclk = 1'b0;
      rx = {rx[14:0], so_w};
      last_q = so_w;
      repeat (gap) @(negedge clk);
    end
    cs_n = 1'b1;
    si = ~si;
    repeat (10) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// [tb/ssrr_readout_bench.sv]
// Self-checking bench for the serial status readout bank.
// Assumes ssrr_host drives the pins and ssrr_checker is bound.
`default_nettype none
module ssrr_readout_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID = 8'h5A; // Arbitrary identity value
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] ev_dev = 5'h00; // pump, clock, under, over, test
  logic [15:0] ev_ch = 16'h0000; // shutdown, warning, on, off nibbles
  logic [11:0] ev_oc = 12'h000;
  logic [13:0] lv = 14'h0000; // fail mode, limp, levels, active, comparators
  logic [4:0] m_dev = 5'h00;
  logic [15:0] m_ch = 16'h0000;
  logic [11:0] m_oc = 12'h000;
  logic m_rcf = 1'b1;
  logic m_serial_fail_flag = 1'b0;
  logic [3:0] paddr = 4'h0;
  int error_cnt, check_count, cyc;
  wire cs_n, sclk, si, so, so_oe;
  always #10 clk = ~clk;
  ssrr_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe));
  ssrr_readout #(.IDENTITY_FIELD(ID)) DUT (.clk(clk), .reset_n(reset_n), .spi_cs_n_pin(cs_n),
    .spi_sclk_pin(sclk), .spi_si_pin(si), .spi_so_out(so), .spi_so_oe(so_oe), .fail_mode_flag(lv[0]),
    .charge_pump_fault(ev_dev[0]), .pwm_clock_fail(ev_dev[1]), .undervoltage_flag(ev_dev[2]),
    .overvoltage_flag(ev_dev[3]), .test_mode_active_flag(ev_dev[4]), .limp_home_pin_level(lv[1]),
    .overtemp_shutdown(ev_ch[3:0]), .overtemp_warning(ev_ch[7:4]), .open_load_on_state(ev_ch[11:8]),
    .open_load_off_state(ev_ch[15:12]), .overcurrent_code(ev_oc), .channel_input_level(lv[5:2]),
    .channel_input_active(lv[9:6]), .output_comparator_level(lv[13:10]));
  function automatic logic [11:0] expd(input logic [3:0] a);
    logic [3:0] oca, qs, hdr;
    int k;
    for (k = 0; k < 4; k++) oca[k] = |m_oc[3*k +: 3];
    qs = oca | m_ch[3:0] | m_ch[7:4] | m_ch[11:8] | m_ch[15:12];
    hdr = {lv[0], m_rcf | (|m_dev), |(oca | m_ch[3:0]), |m_ch[15:8]};
    k = int'(a) - 2;
    case (a)
      4'h1: expd = {hdr, m_dev[0], m_rcf, m_dev[1], 1'b0, qs};
      4'h2, 4'h3, 4'h4, 4'h5: expd = {hdr, 1'b0, m_ch[k], m_ch[4+k], m_oc[3*k +: 3], m_ch[8+k], m_ch[12+k]};
      4'h7: expd = {hdr, 3'h0, m_dev[4], m_dev[3], m_dev[2], m_serial_fail_flag, lv[1]};
      4'h8: expd = {lv[0], 1'b0, |lv[9:6], lv[5:2], 1'b0, lv[13:10]};
      4'h9: expd = {4'h0, ID};
      default: expd = 12'h000;
    endcase
  endfunction
  task automatic pulse(input logic [2:0] c);
    @(negedge clk);
    ev_dev = 5'($urandom & $urandom);
    ev_ch = 16'($urandom & $urandom);
    ev_oc = {9'($urandom), c};
    m_dev |= ev_dev;
    m_ch |= ev_ch;
    for (int k = 0; k < 4; k++)
      if (ev_oc[3*k +: 3] != 3'h0 && ev_oc[3*k +: 3] != 3'h7) m_oc[3*k +: 3] = ev_oc[3*k +: 3];
    @(negedge clk);
    ev_dev = 5'h00;
    ev_ch = 16'h0000;
    ev_oc = 12'h000;
  endtask
  // One frame; the answer carries the register named by the last good frame
  task automatic xf(input logic [3:0] a, input int nb);
    logic [15:0] got, exp;
    int k;
    @(negedge clk);
    lv = 14'($urandom);
    repeat (3) @(negedge clk);
    exp = {paddr, expd(paddr)};
    host.frame({a, 12'($urandom)}, nb, 6 + int'($urandom % 4), got);
    if (nb != 16) begin
      m_serial_fail_flag = 1'b1;
      return;
    end
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
    k = int'(paddr) - 2;
    if (paddr == 4'h1) m_dev[1:0] = 2'h0;
    if (paddr == 4'h1) m_rcf = 1'b0;
    if (k >= 0 && k < 4) m_ch &= ~(16'h1111 << k);
    if (k >= 0 && k < 4) m_oc[3*k +: 3] = 3'h0;
    if (paddr == 4'h7) m_dev[4:2] = 3'h0;
    if (paddr == 4'h7) m_serial_fail_flag = 1'b0;
    paddr = a;
  endtask
  task automatic close_out;
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hB0FE3D06));
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    xf(4'h7, 16);
    xf(4'h1, 16);
    xf(4'h1, 16);
    $display("test reset values done");
    xf(4'h8, 9);
    xf(4'h7, 16);
    xf(4'h2, 16);
    $display("test refused frame done");
    for (int a = 0; a < 16; a++) begin
      pulse(3'(a));
      xf(4'(a), 16);
      xf(4'(15 - a), 16);
    end
    $display("test address sweep done");
    @(negedge clk);
    reset_n = 1'b0;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    {m_dev, m_ch, m_oc, m_serial_fail_flag, paddr} = '0;
    m_rcf = 1'b1;
    repeat (3) @(negedge clk);
    xf(4'h1, 16);
    xf(4'h7, 16);
    $display("test mid-run reset done");
    repeat (24) begin
      pulse(3'($urandom));
      xf(4'($urandom), 16);
    end
    $display("test random traffic done");
    close_out;
  end
  // Ceiling is about twice the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      close_out;
    end
  end
endmodule
`default_nettype wire
